// ---- delb_pkg.sv ----
// package for the deferred error logging bank: register indices,
// field positions, reset values, event and access carriers.
// assumes a single core clock and a synchronous register access port.
`default_nettype none
package delb_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths and reset values
    localparam int unsigned DATA_W = 64;
    localparam logic [63:0] RST_ZERO = 64'h0;

    ////////////////////////////////////////////////////////////////////////
    // bank register indices
    localparam logic [3:0] IDX_CTL = 4'h0;
    localparam logic [3:0] IDX_STATUS = 4'h1;
    localparam logic [3:0] IDX_ADDR = 4'h2;
    localparam logic [3:0] IDX_MISC0 = 4'h3;
    localparam logic [3:0] IDX_CONFIG = 4'h4;
    localparam logic [3:0] IDX_IPID = 4'h5;
    localparam logic [3:0] IDX_SYND = 4'h6;
    localparam logic [3:0] IDX_DESTAT = 4'h8;
    localparam logic [3:0] IDX_DEADDR = 4'h9;
    localparam logic [3:0] IDX_MISCX_FIRST = 4'ha;
    localparam logic [3:0] IDX_MISCX_LAST = 4'hd;
    localparam logic [3:0] IDX_SYNDX_FIRST = 4'he;

    // global register indices
    localparam logic [3:0] GIDX_CAP = 4'h0;
    localparam logic [3:0] GIDX_CTL = 4'h1;
    localparam logic [3:0] GIDX_CR4 = 4'h2;

    ////////////////////////////////////////////////////////////////////////
    // status record fields, shared by primary and deferred status
    localparam int unsigned ST_VALID = 63;
    localparam int unsigned ST_OVER = 62;
    localparam int unsigned ST_UC = 61;
    localparam int unsigned ST_ADDRESS_VALID_FLAG = 58;
    localparam int unsigned ST_SYNDROME_VALID_FLAG = 53;
    localparam int unsigned ST_DEFERRED = 44;
    localparam int unsigned ST_EXT_LSB = 16;
    localparam int unsigned ST_CODE_LSB = 0;
    localparam int unsigned CODE_W = 16;

    // bank configuration fields
    localparam int unsigned CFG_INT_EN = 40;
    localparam int unsigned CFG_DEF_TYPE_LSB = 37;
    localparam int unsigned CFG_DUAL_LOG = 34;
    localparam int unsigned CFG_CODE_CAP = 7;
    localparam int unsigned CFG_DEF_LOG_SUP = 2;
    localparam logic [1:0] DEF_INT_APIC = 2'h1;
    localparam logic [1:0] DEF_INT_SMI = 2'h2;

    // global capability and control fields
    localparam int unsigned CAP_COUNT_W = 8;
    localparam int unsigned CAP_GLOBAL_CONTROL_PRESENT = 8;
    localparam int unsigned CR4_MCE_BIT = 0;

    // first miscellaneous register: threshold low, count high
    localparam int unsigned MISC_THR_LSB = 0;
    localparam int unsigned MISC_CNT_LSB = 32;
    localparam int unsigned MISC_CNT_W = 12;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        CLS_CORR = 2'h0,
        CLS_DEFER = 2'h1,
        CLS_UNCORR = 2'h2
    } delb_class_t;

    typedef enum logic [1:0] {
        CORE_RUN = 2'b01,
        CORE_SHUT = 2'b10
    } delb_core_t;

    typedef struct packed {
        logic valid;
        delb_class_t cls;
        logic [5:0] type_idx;
        logic addr_valid;
        logic synd_valid;
        logic [15:0] ext_code;
        logic [15:0] code;
        logic [63:0] addr;
        logic [63:0] synd;
        logic [1:0][63:0] synd_x;
        logic [3:0][63:0] misc;
    } delb_err_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic glob;
        logic [3:0] idx;
        logic [63:0] wdata;
    } delb_req_t;

    typedef struct packed {
        logic valid;
        logic [63:0] data;
    } delb_rsp_t;

endpackage : delb_pkg
`default_nettype wire

// ---- delb_ce_counter.sv ----
// corrected error counter with a software threshold.
// assumes inc_i and load_i are single-cycle strobes on clk_i.
`default_nettype none
module delb_ce_counter #(
    parameter int unsigned CNT_W = delb_pkg::MISC_CNT_W
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // control
    input wire logic load_i,
    input wire logic [CNT_W-1:0] load_val_i,
    input wire logic inc_i,
    input wire logic [CNT_W-1:0] threshold_i,
    // result
    output logic [CNT_W-1:0] count_o,
    output logic hit_o
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic hit_reg;
    logic at_max;
    logic [CNT_W-1:0] cnt_base;

    // a load and an increment together: the increment wins on the loaded value
    assign cnt_base = load_i ? load_val_i : cnt_reg;
    assign at_max = &cnt_base;
    assign cnt_next = (inc_i && !at_max) ? cnt_base + 1'b1 : cnt_base;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= '0;
            hit_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            hit_reg <= inc_i && !at_max && (cnt_next == threshold_i); // [RL20]
        end
    end

    assign count_o = cnt_reg;
    assign hit_o = hit_reg;

endmodule // delb_ce_counter
`default_nettype wire

// ---- delb_bank.sv ----
// one machine-check error logging bank with its deferred error record,
// plus the global capability, bank enable and exception enable state.
// assumes err_i.valid is a one-cycle strobe and req_i is synchronous.
`default_nettype none

// How it works
// [RL1] a deferred error is recorded into the deferred status register
// [RL2] the deferred record survives later, more severe errors in the bank
// [RL3] deferred status bit 63 marks a valid record
// [RL4] deferred status bit 62 marks a deferred error that was dropped
// [RL5] deferred status bit 58 marks a valid deferred address
// [RL6] deferred status bit 53 marks valid syndrome data
// [RL7] deferred status bit 44 marks the record as deferred class
// [RL8] bits 31:16 and 15:0 hold codes only when the code capability is set
// [RL9] deferred address captured like the primary address, valid with 63,58
// [RL10] four extra misc registers are hardware written, first-misc layout
// [RL11] two extra syndrome registers filled when either syndrome bit set
// [RL12] every reporting enable is cleared by reset
// [RL13] global enable exists only when present bit set; ones enable all
// [RL14] capability count reports the number of banks
// [RL15] bank enable gates reporting per error type, bit by bit
// [RL16] status registers survive a warm reset
// [RL17] writing zeros clears a status register and it stays cleared
// [RL18] exception enable bit set raises exception, clear means shutdown
// [RL19] enabled uncorrected errors transfer control to the exception
// [RL20] interrupt on deferred error or corrected count reaching threshold
// [RL21] status registers are always readable regardless of enables
// [RL22] software clears deferred and matching primary status after handling
// [RL23] dual log enable also logs deferred errors in the primary registers
// [RL24] configuration bit 7 reports the deferred code capability
// [RL25] deferred error on a valid record sets overflow, keeps the record
module delb_bank #(
    parameter int unsigned BANK_COUNT = 8,
    parameter int unsigned BANK_ID = 0,
    parameter bit CTL_PRESENT = 1'b1,
    parameter bit CODE_CAP = 1'b1,
    // identification value is arbitrary
    parameter logic [63:0] IPID_VALUE = 64'h0000_0000_0000_0001
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic warm_rst_i,
    // register access
    input wire delb_pkg::delb_req_t req_i,
    output var delb_pkg::delb_rsp_t rsp_o,
    // detected errors
    input wire delb_pkg::delb_err_t err_i,
    // reporting
    output logic mce_o,
    output logic shutdown_o,
    output logic defer_int_o,
    output logic defer_smi_o,
    output logic thresh_int_o
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic wr_hit(delb_pkg::delb_req_t r, logic g,
                                    logic [3:0] i);
        return r.wr && (r.glob == g) && (r.idx == i);
    endfunction

    function automatic logic [63:0] make_rec(delb_pkg::delb_err_t e,
                                             logic with_code);
        logic [63:0] v;
        v = delb_pkg::RST_ZERO;
        v[delb_pkg::ST_VALID] = 1'b1; // [RL3]
        v[delb_pkg::ST_UC] = (e.cls == delb_pkg::CLS_UNCORR);
        v[delb_pkg::ST_ADDRESS_VALID_FLAG] = e.addr_valid; // [RL5]
        v[delb_pkg::ST_SYNDROME_VALID_FLAG] = e.synd_valid; // [RL6]
        v[delb_pkg::ST_DEFERRED] = (e.cls == delb_pkg::CLS_DEFER); // [RL7]
        if (with_code) begin
            v[delb_pkg::ST_EXT_LSB +: delb_pkg::CODE_W] = e.ext_code; // [RL8]
            v[delb_pkg::ST_CODE_LSB +: delb_pkg::CODE_W] = e.code;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [63:0] ctl_reg;
    logic [63:0] status_reg;
    logic [63:0] addr_reg;
    logic [63:0] misc0_reg;
    logic [63:0] synd_reg;
    logic [63:0] destat_reg;
    logic [63:0] deaddr_reg;
    logic [63:0] miscx_reg [4];
    logic [63:0] syndx_reg [2];
    logic [BANK_COUNT-1:0] gctl_reg;
    logic mce_en_reg;
    logic cfg_int_en_reg;
    logic [1:0] cfg_def_type_reg;
    logic cfg_dual_log_reg;
    delb_pkg::delb_core_t core_reg;
    delb_pkg::delb_rsp_t rsp_reg;
    logic mce_reg;
    logic defer_int_reg;
    logic defer_smi_reg;

    ////////////////////////////////////////////////////////////////////////
    // access decode

    wire wr_ctl = wr_hit(req_i, 1'b0, delb_pkg::IDX_CTL);
    wire wr_status = wr_hit(req_i, 1'b0, delb_pkg::IDX_STATUS);
    wire wr_addr = wr_hit(req_i, 1'b0, delb_pkg::IDX_ADDR);
    wire wr_misc0 = wr_hit(req_i, 1'b0, delb_pkg::IDX_MISC0);
    wire wr_config = wr_hit(req_i, 1'b0, delb_pkg::IDX_CONFIG);
    wire wr_synd = wr_hit(req_i, 1'b0, delb_pkg::IDX_SYND);
    wire wr_destat = wr_hit(req_i, 1'b0, delb_pkg::IDX_DESTAT);
    wire wr_deaddr = wr_hit(req_i, 1'b0, delb_pkg::IDX_DEADDR);
    wire wr_gctl = wr_hit(req_i, 1'b1, delb_pkg::GIDX_CTL);
    wire wr_cr4 = wr_hit(req_i, 1'b1, delb_pkg::GIDX_CR4);
    wire [1:0] miscx_sel = 2'(req_i.idx - delb_pkg::IDX_MISCX_FIRST);
    wire syndx_sel = req_i.idx[0];
    wire in_miscx = (req_i.idx >= delb_pkg::IDX_MISCX_FIRST) &&
                    (req_i.idx <= delb_pkg::IDX_MISCX_LAST);
    wire in_syndx = (req_i.idx >= delb_pkg::IDX_SYNDX_FIRST);

    ////////////////////////////////////////////////////////////////////////
    // event classification

    wire ev = err_i.valid;
    wire ev_def = ev && (err_i.cls == delb_pkg::CLS_DEFER);
    wire ev_unc = ev && (err_i.cls == delb_pkg::CLS_UNCORR);
    wire ev_cor = ev && (err_i.cls == delb_pkg::CLS_CORR);

    // a write in the same cycle is applied first, so the event wins
    wire [63:0] destat_base = wr_destat ? req_i.wdata : destat_reg; // [RL17]
    wire [63:0] status_base = wr_status ? req_i.wdata : status_reg; // [RL17]

    wire def_free = !destat_base[delb_pkg::ST_VALID];
    wire def_log = ev_def && def_free; // [RL1]
    wire def_drop = ev_def && !def_free; // [RL25]

    wire prim_take = ev_unc || ev_cor ||
                     (ev_def && cfg_dual_log_reg); // [RL23]
    wire prim_free = !status_base[delb_pkg::ST_VALID] ||
                     (ev_unc && !status_base[delb_pkg::ST_UC]);
    wire prim_log = prim_take && prim_free;
    wire prim_drop = prim_take && !prim_free;
    wire any_log = def_log || prim_log;
    wire synd_log = any_log && err_i.synd_valid; // [RL11]

    wire bank_on = CTL_PRESENT ? gctl_reg[BANK_ID] : 1'b1; // [RL13]
    wire type_on = ctl_reg[err_i.type_idx]; // [RL15]
    wire report = ev_unc && bank_on && type_on; // [RL19]

    ////////////////////////////////////////////////////////////////////////
    // status and address records, untouched by warm reset

    wire [63:0] destat_next =
        def_log ? make_rec(err_i, CODE_CAP) : // [RL1]
        def_drop ? (destat_base | (64'h1 << delb_pkg::ST_OVER)) : // [RL4]
        destat_base;

    wire [63:0] status_next =
        prim_log ? make_rec(err_i, 1'b1) :
        prim_drop ? (status_base | (64'h1 << delb_pkg::ST_OVER)) :
        status_base; // [RL2]

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            destat_reg <= delb_pkg::RST_ZERO;
            status_reg <= delb_pkg::RST_ZERO;
        end else begin
            destat_reg <= destat_next; // [RL16]
            status_reg <= status_next; // [RL16]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            deaddr_reg <= delb_pkg::RST_ZERO;
        end else if (def_log && err_i.addr_valid) begin
            deaddr_reg <= err_i.addr; // [RL9]
        end else if (wr_deaddr) begin
            deaddr_reg <= req_i.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_reg <= delb_pkg::RST_ZERO;
        end else if (prim_log && err_i.addr_valid) begin
            addr_reg <= err_i.addr; // [RL23]
        end else if (wr_addr) begin
            addr_reg <= req_i.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            synd_reg <= delb_pkg::RST_ZERO;
        end else if (synd_log) begin
            synd_reg <= err_i.synd; // [RL6]
        end else if (wr_synd) begin
            synd_reg <= req_i.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // extra miscellaneous and syndrome registers, hardware written

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 4; i++) begin
                miscx_reg[i] <= delb_pkg::RST_ZERO;
            end
        end else if (any_log) begin
            for (int i = 0; i < 4; i++) begin
                miscx_reg[i] <= err_i.misc[i]; // [RL10]
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 2; i++) begin
                syndx_reg[i] <= delb_pkg::RST_ZERO;
            end
        end else if (synd_log) begin
            for (int i = 0; i < 2; i++) begin
                syndx_reg[i] <= err_i.synd_x[i]; // [RL11]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enables and configuration, cleared by either reset, except misc0_reg, which only arst_n_i clears

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl_reg <= delb_pkg::RST_ZERO; // [RL12]
        end else if (warm_rst_i) begin
            ctl_reg <= delb_pkg::RST_ZERO; // [RL12]
        end else if (wr_ctl) begin
            ctl_reg <= req_i.wdata; // [RL15]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gctl_reg <= '0; // [RL12]
        end else if (warm_rst_i) begin
            gctl_reg <= '0;
        end else if (wr_gctl && CTL_PRESENT) begin
            gctl_reg <= req_i.wdata[BANK_COUNT-1:0]; // [RL13]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mce_en_reg <= 1'b0; // [RL12]
        end else if (warm_rst_i) begin
            mce_en_reg <= 1'b0;
        end else if (wr_cr4) begin
            mce_en_reg <= req_i.wdata[delb_pkg::CR4_MCE_BIT]; // [RL18]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_int_en_reg <= 1'b0;
            cfg_def_type_reg <= 2'h0;
            cfg_dual_log_reg <= 1'b0;
        end else if (warm_rst_i) begin
            cfg_int_en_reg <= 1'b0; // [RL12]
            cfg_def_type_reg <= 2'h0;
            cfg_dual_log_reg <= 1'b0;
        end else if (wr_config) begin
            cfg_int_en_reg <= req_i.wdata[delb_pkg::CFG_INT_EN];
            cfg_def_type_reg <= req_i.wdata[delb_pkg::CFG_DEF_TYPE_LSB +: 2];
            cfg_dual_log_reg <= req_i.wdata[delb_pkg::CFG_DUAL_LOG];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            misc0_reg <= delb_pkg::RST_ZERO;
        end else if (wr_misc0) begin
            misc0_reg <= req_i.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // corrected error threshold

    logic [delb_pkg::MISC_CNT_W-1:0] ce_count;
    logic ce_hit;

    delb_ce_counter #(
        .CNT_W(delb_pkg::MISC_CNT_W)
    ) delb_ce_counter_i (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .load_i(wr_misc0),
        .load_val_i(req_i.wdata[delb_pkg::MISC_CNT_LSB +:
                                delb_pkg::MISC_CNT_W]),
        .inc_i(ev_cor),
        .threshold_i(misc0_reg[delb_pkg::MISC_THR_LSB +:
                               delb_pkg::MISC_CNT_W]),
        .count_o(ce_count),
        .hit_o(ce_hit)
    );

    assign thresh_int_o = ce_hit && cfg_int_en_reg; // [RL20]

    ////////////////////////////////////////////////////////////////////////
    // exception, shutdown and deferred interrupts

    wire go_shut = report && !mce_en_reg; // [RL18]

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            core_reg <= delb_pkg::CORE_RUN;
        end else begin
            unique case (core_reg)
                delb_pkg::CORE_RUN: begin
                    if (go_shut) begin
                        core_reg <= delb_pkg::CORE_SHUT; // [RL18]
                    end
                end
                delb_pkg::CORE_SHUT: begin
                    if (warm_rst_i) begin
                        core_reg <= delb_pkg::CORE_RUN;
                    end
                end
                default: begin
                    core_reg <= delb_pkg::CORE_RUN;
                end
            endcase
        end
    end

    wire running = (core_reg == delb_pkg::CORE_RUN);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mce_reg <= 1'b0;
            defer_int_reg <= 1'b0;
            defer_smi_reg <= 1'b0;
        end else begin
            mce_reg <= running && report && mce_en_reg; // [RL19]
            defer_int_reg <= def_log &&
                (cfg_def_type_reg == delb_pkg::DEF_INT_APIC); // [RL20]
            defer_smi_reg <= def_log &&
                (cfg_def_type_reg == delb_pkg::DEF_INT_SMI); // [RL20]
        end
    end

    assign mce_o = mce_reg;
    assign shutdown_o = (core_reg == delb_pkg::CORE_SHUT);
    assign defer_int_o = defer_int_reg;
    assign defer_smi_o = defer_smi_reg;

    ////////////////////////////////////////////////////////////////////////
    // read side, open at all times

    logic [63:0] cfg_rd;
    logic [63:0] misc0_rd;
    logic [63:0] cap_rd;
    logic [63:0] bank_rd;
    logic [63:0] glob_rd;

    always_comb begin
        cfg_rd = delb_pkg::RST_ZERO;
        cfg_rd[delb_pkg::CFG_INT_EN] = cfg_int_en_reg;
        cfg_rd[delb_pkg::CFG_DEF_TYPE_LSB +: 2] = cfg_def_type_reg;
        cfg_rd[delb_pkg::CFG_DUAL_LOG] = cfg_dual_log_reg;
        cfg_rd[delb_pkg::CFG_CODE_CAP] = CODE_CAP; // [RL24]
        cfg_rd[delb_pkg::CFG_DEF_LOG_SUP] = 1'b1;
        misc0_rd = misc0_reg;
        misc0_rd[delb_pkg::MISC_CNT_LSB +: delb_pkg::MISC_CNT_W] = ce_count;
        cap_rd = delb_pkg::RST_ZERO;
        cap_rd[delb_pkg::CAP_COUNT_W-1:0] =
            BANK_COUNT[delb_pkg::CAP_COUNT_W-1:0]; // [RL14]
        cap_rd[delb_pkg::CAP_GLOBAL_CONTROL_PRESENT] = CTL_PRESENT;
    end

    always_comb begin
        bank_rd = delb_pkg::RST_ZERO;
        unique case (req_i.idx)
            delb_pkg::IDX_CTL: bank_rd = ctl_reg;
            delb_pkg::IDX_STATUS: bank_rd = status_reg; // [RL21]
            delb_pkg::IDX_ADDR: bank_rd = addr_reg;
            delb_pkg::IDX_MISC0: bank_rd = misc0_rd;
            delb_pkg::IDX_CONFIG: bank_rd = cfg_rd;
            delb_pkg::IDX_IPID: bank_rd = IPID_VALUE;
            delb_pkg::IDX_SYND: bank_rd = synd_reg;
            delb_pkg::IDX_DESTAT: bank_rd = destat_reg; // [RL21]
            delb_pkg::IDX_DEADDR: bank_rd = deaddr_reg;
            default: begin
                if (in_miscx) begin
                    bank_rd = miscx_reg[miscx_sel];
                end else if (in_syndx) begin
                    bank_rd = syndx_reg[syndx_sel];
                end
            end
        endcase
    end

    always_comb begin
        glob_rd = delb_pkg::RST_ZERO;
        if (req_i.idx == delb_pkg::GIDX_CAP) begin
            glob_rd = cap_rd;
        end else if (req_i.idx == delb_pkg::GIDX_CTL && CTL_PRESENT) begin
            glob_rd[BANK_COUNT-1:0] = gctl_reg;
        end else if (req_i.idx == delb_pkg::GIDX_CR4) begin
            glob_rd[delb_pkg::CR4_MCE_BIT] = mce_en_reg;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.valid <= req_i.rd;
            rsp_reg.data <= req_i.glob ? glob_rd : bank_rd;
        end
    end

    assign rsp_o = rsp_reg;

endmodule // delb_bank
`default_nettype wire

// ---- delb_bank_chk.sv ----
// assertions on the bank top ports.
// assumes binding by name into delb_bank.
`default_nettype none
module delb_bank_chk #(
    parameter int unsigned BANK_COUNT = 8,
    parameter bit CTL_PRESENT = 1'b1
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic warm_rst_i,
    // access and errors
    input wire delb_pkg::delb_req_t req_i,
    input wire delb_pkg::delb_rsp_t rsp_o,
    input wire delb_pkg::delb_err_t err_i,
    // reporting
    input wire logic mce_o,
    input wire logic shutdown_o,
    input wire logic defer_int_o,
    input wire logic defer_smi_o,
    input wire logic thresh_int_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    wire cap_rd = req_i.rd && req_i.glob && req_i.idx == delb_pkg::GIDX_CAP;
    ////////////////////////////////////////////////////////////////////////
    rd_answer_a: assert property (req_i.rd |=> rsp_o.valid)
        else $error("read not answered");
    no_stray_a: assert property (!req_i.rd |=> !rsp_o.valid)
        else $error("answer without read");
    cap_count_a: assert property (cap_rd |=>
        rsp_o.data[7:0] == BANK_COUNT[7:0]) else $error("bad bank count");
    ctl_flag_a: assert property (cap_rd |=>
        rsp_o.data[8] == CTL_PRESENT) else $error("bad present flag");
    mce_cause_a: assert property (mce_o |-> $past(err_i.valid) &&
        $past(err_i.cls) == delb_pkg::CLS_UNCORR) else $error("stray mce");
    shut_cause_a: assert property ($rose(shutdown_o) |->
        $past(err_i.valid)) else $error("stray shutdown");
    shut_hold_a: assert property (shutdown_o && !warm_rst_i |=>
        shutdown_o) else $error("shutdown dropped");
    warm_exit_a: assert property (warm_rst_i && !err_i.valid |=>
        !shutdown_o) else $error("warm reset kept shutdown");
    shut_quiet_a: assert property (shutdown_o |=> !mce_o)
        else $error("mce in shutdown");
    defer_cause_a: assert property (defer_int_o || defer_smi_o |->
        $past(err_i.cls) == delb_pkg::CLS_DEFER) else $error("stray int");
    thr_cause_a: assert property (thresh_int_o |->
        $past(err_i.valid) && $past(err_i.cls) == delb_pkg::CLS_CORR)
        else $error("stray threshold interrupt");
endmodule // delb_bank_chk
bind delb_bank delb_bank_chk #(.BANK_COUNT(BANK_COUNT),
    .CTL_PRESENT(CTL_PRESENT)) delb_bank_chk_i (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .warm_rst_i(warm_rst_i), .req_i(req_i),
    .rsp_o(rsp_o), .err_i(err_i), .mce_o(mce_o), .shutdown_o(shutdown_o),
    .defer_int_o(defer_int_o), .defer_smi_o(defer_smi_o),
    .thresh_int_o(thresh_int_o));
`default_nettype wire

// ---- delb_bank_tb_top.sv ----
// self-checking bench for the bank.
// assumes the package and bank are compiled first.
`default_nettype none
module delb_bank_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, arst_n_i, warm_rst_i, mce_o, shutdown_o, dint, dsmi, tint;
    delb_pkg::delb_req_t req;
    delb_pkg::delb_rsp_t rsp;
    delb_pkg::delb_err_t err, keep;
    logic [63:0] q[$];
    logic [63:0] v;
    int mismatches = 0, checked = 0, cyc = 0;
    delb_bank delb_bank_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .warm_rst_i(warm_rst_i), .req_i(req), .rsp_o(rsp), .err_i(err),
        .mce_o(mce_o), .shutdown_o(shutdown_o), .defer_int_o(dint),
        .defer_smi_o(dsmi), .thresh_int_o(tint));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 0;
        forever #2 clk_i = ~clk_i;
    end
    task results;
        if (mismatches == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(string n, logic [63:0] s, logic [63:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            results;
        end
        if (rsp.valid === 1'b1) chk("read", rsp.data, q.pop_front());
    end
    task step;
        @(posedge clk_i);
        #1;
    endtask
    task acc(bit w, bit g, logic [3:0] i, logic [63:0] d);
        if (!w) q.push_back(d);
        req = {!w, w, g, i, d};
        step;
        req = '0;
        step;
    endtask
    task fire(delb_pkg::delb_class_t c);
        step;
        err = {1'b1, c, 6'($urandom), 2'h3, $urandom, {16{$urandom}}};
        for (int k = 0; k < 4; k++) err.misc[k] = {$urandom, $urandom};
        for (int k = 0; k < 2; k++) err.synd_x[k] = {$urandom, $urandom};
        if (c == delb_pkg::CLS_DEFER) keep = err;
        step;
        err.valid = 1'b0;
    endtask
    task warm;
        warm_rst_i = 1;
        step;
        warm_rst_i = 0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {arst_n_i, warm_rst_i, req, err} = '0;
        void'($urandom(32'he5f67c3c));
        repeat (16) @(posedge clk_i);
        #1 arst_n_i = 1;
        acc(0, 0, delb_pkg::IDX_DESTAT, 64'h0);
        acc(0, 1, delb_pkg::GIDX_CTL, 64'h0);
        acc(0, 1, delb_pkg::GIDX_CR4, 64'h0);
        acc(0, 1, delb_pkg::GIDX_CAP, 64'h108);
        acc(0, 0, delb_pkg::IDX_CONFIG, 64'h84);
        fire(delb_pkg::CLS_DEFER);
        v = 64'h8420_1000_0000_0000 | {32'h0, keep.ext_code, keep.code};
        acc(0, 0, delb_pkg::IDX_DESTAT, v);
        acc(0, 0, delb_pkg::IDX_DEADDR, keep.addr);
        for (int i = 0; i < 4; i++)
            acc(0, 0, 4'(10 + i), keep.misc[i]);
        for (int i = 0; i < 2; i++)
            acc(0, 0, 4'(14 + i), keep.synd_x[i]);
        fire(delb_pkg::CLS_DEFER);
        acc(0, 0, delb_pkg::IDX_DESTAT, v | 64'h4000_0000_0000_0000);
        fire(delb_pkg::CLS_UNCORR);
        chk("mce", {mce_o, shutdown_o}, 64'h0);
        warm;
        acc(0, 0, delb_pkg::IDX_DESTAT, v | 64'h4000_0000_0000_0000);
        acc(1, 0, delb_pkg::IDX_DESTAT, 64'h0);
        acc(0, 0, delb_pkg::IDX_DESTAT, 64'h0);
        acc(1, 1, delb_pkg::GIDX_CTL, '1);
        acc(1, 0, delb_pkg::IDX_CTL, '1);
        acc(1, 1, delb_pkg::GIDX_CR4, 64'h1);
        fire(delb_pkg::CLS_UNCORR);
        chk("mce", mce_o, 64'h1);
        acc(1, 1, delb_pkg::GIDX_CR4, 64'h0);
        fire(delb_pkg::CLS_UNCORR);
        chk("shut", {mce_o, shutdown_o}, 64'h1);
        warm;
        acc(1, 0, delb_pkg::IDX_STATUS, 64'h0);
        acc(1, 0, delb_pkg::IDX_CONFIG, 64'h0000_0124_0000_0000);
        fire(delb_pkg::CLS_DEFER);
        chk("dint", {dint, dsmi}, 64'h2);
        v = 64'h8420_1000_0000_0000 | {32'h0, keep.ext_code, keep.code};
        acc(0, 0, delb_pkg::IDX_STATUS, v);
        acc(0, 0, delb_pkg::IDX_ADDR, keep.addr);
        acc(1, 0, delb_pkg::IDX_MISC0, 64'h2);
        fire(delb_pkg::CLS_CORR);
        chk("tint", tint, 64'h0);
        fire(delb_pkg::CLS_CORR);
        chk("tint", tint, 64'h1);
        acc(1, 0, delb_pkg::IDX_DESTAT, 64'h0);
        acc(1, 0, delb_pkg::IDX_CONFIG, 64'h0000_0140_0000_0000);
        fire(delb_pkg::CLS_DEFER);
        chk("dsmi", {dint, dsmi}, 64'h1);
        step;
        results;
    end
endmodule // delb_bank_tb_top
`default_nettype wire
